// ===== rtl/pmac_pkg.sv
/*
  constants, field layout and state type for the power monitor alert
  and configuration block.
  assumes a 10 MHz system clock and a decoded register access port.
*/
package pmac_pkg;

  // register addresses on the decoded serial access port
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CUR = 8'h01;
  localparam logic [7:0] ADDR_BUS = 8'h02;
  localparam logic [7:0] ADDR_PWR = 8'h03;
  localparam logic [7:0] ADDR_MASK = 8'h06;
  localparam logic [7:0] ADDR_LIM = 8'h07;
  localparam logic [7:0] ADDR_ID = 8'hff;

  // configuration register fields
  localparam int CFG_RST_BIT = 15;
  localparam int CFG_AVG_LSB = 9;
  localparam int CFG_VCT_LSB = 6;
  localparam int CFG_SCT_LSB = 3;
  localparam int CFG_MODE_LSB = 0;
  localparam int MODE_CONT_BIT = 2;
  localparam logic [15:0] CFG_RESET = 16'h6007;

  // mask/enable register fields
  localparam int MASK_EN_LSB = 10;
  localparam int MASK_AFF_BIT = 4;
  localparam int MASK_CONVERSION_READY_FLAG_BIT = 3;
  localparam int MASK_OVF_BIT = 2;
  localparam int MASK_ALERT_POLARITY_BIT = 1;
  localparam int MASK_LEN_BIT = 0;
  // index into the six enables: over-current down to conversion ready
  localparam int EN_OCL = 5;
  localparam int EN_UCL = 4;
  localparam int EN_BOL = 3;
  localparam int EN_BUL = 2;
  localparam int EN_POL = 1;
  localparam int EN_CONV_READY_ALERT_ENABLE = 0;

  // identification: values are arbitrary
  localparam logic [11:0] DEVICE_CODE = 12'h5a5;
  localparam logic [3:0] DIE_REVISION = 4'h3;

  // conversion timing: the time unit doubles with each step of the conversion time code
  localparam int CLK_MHZ = 10;
  localparam int CT_UNIT_US = 140;
  localparam int CT_UNIT_CYCLES = CT_UNIT_US * CLK_MHZ;

  // power scaling: product bits dropped to land in watts format
  localparam int PWR_SHIFT = 8;

  // whole state of the main module
  typedef struct packed {
    logic [15:0] cfg;        // configuration register
    logic [5:0] alert_en;    // alert function enables
    logic aff;               // alert source flag
    logic conversion_ready_flag;              // conversion ready flag
    logic ovf;               // math overflow flag
    logic alert_polarity;              // alert polarity
    logic len;               // latch enable
    logic [15:0] limit;      // alert threshold
    logic [15:0] cur;        // current result
    logic [15:0] bus;        // bus voltage result
    logic [15:0] pwr;        // power result
    logic [15:0] rdata;      // read data
    logic [23:0] tmr;        // conversion timer
    logic armed;             // one-shot pending
    logic alert_oe;          // alert pin pulled low
    logic alert_lvl;         // level driven on the alert pin
  } pmac_state_t;

endpackage

// ===== rtl/pmac_avg.sv
/*
  sample averager: sums a power-of-two number of samples and delivers
  the mean with a one-cycle done pulse.
  assumes sample_en_i pulses once per conversion and shift_i <= 10.
*/
`timescale 1ns/100ps
module pmac_avg (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic sample_en_i,
  input wire logic signed [16:0] sample_i,
  input wire logic [3:0] shift_i,
  output logic signed [31:0] sum_o,
  output logic [15:0] avg_o,
  output logic done_o
);

  // averager state
  typedef struct packed {
    logic signed [31:0] sum;  // running sum of this block
    logic [10:0] cnt;         // samples taken so far
    logic [15:0] avg;         // last mean
    logic done;               // mean just updated
  } pmac_avg_state_t;

  pmac_avg_state_t s;
  pmac_avg_state_t next_s;
  logic signed [31:0] nsum;
  logic signed [31:0] mean;

  // next-state: add the sample and close the block after 2^shift samples
  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    nsum = s.sum + 32'(sample_i);
    mean = nsum >>> shift_i;
    if (clear_i)
    begin
      next_s.sum = '0;
      next_s.cnt = '0;
    end
    else if (sample_en_i)
    begin
      if ((s.cnt + 11'h1) == (11'h1 << shift_i))
      begin
        next_s.avg = mean[15:0];
        next_s.done = 1'b1;
        next_s.sum = '0;
        next_s.cnt = '0;
      end
      else
      begin
        next_s.sum = nsum;
        next_s.cnt = s.cnt + 11'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign sum_o = s.sum;
  assign avg_o = s.avg;
  assign done_o = s.done;

endmodule

// ===== rtl/pmac_top.sv
/*
  power monitor configuration, alert and identification logic: register
  file, conversion timer, averaging, power product and alert pin.
  assumes the serial protocol engine outside decodes each access into one
  read or write strobe with address and data, synchronous to clk_i.
*/
// Behaviour
// RQ1 - read-only id: device code and revision
// RQ2 - alert follows one function or ready
// RQ3 - marginal fault alerts within one-two conversions
// RQ4 - large fault alerts early from partial average; code does it only for bus over-limit with the bus channel on
// RQ5 - configuration register: reset, averaging, times, mode
// RQ6 - mask register: enables, flags, polarity, latch
// RQ7 - sixteen-bit threshold compared to selected measurement
// RQ8 - host sets config, alert function, threshold
// RQ9 - current, voltage, power results directly scaled
// RQ10 - latch clears flag on read; transparent otherwise
// RQ11 - polarity bit: one active-high, zero active-low
`timescale 1ns/100ps
module pmac_top #(
  parameter int CONV_UNIT_CYCLES = pmac_pkg::CT_UNIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [15:0] current_i,
  input wire logic [15:0] bus_i,
  output logic alert_o,
  output logic alert_oe_o
);

  // reset image of the whole state
  localparam pmac_pkg::pmac_state_t ST_RESET = '{cfg: pmac_pkg::CFG_RESET, default: '0};

  pmac_pkg::pmac_state_t s;
  pmac_pkg::pmac_state_t next_s;

  // conversion time in cycles for one time code
  function automatic logic [23:0] ct_cycles(input logic [2:0] code);
    ct_cycles = 24'(CONV_UNIT_CYCLES) << code;
  endfunction

  // averaging code to log2 of the sample count
  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    logic [3:0] r;
    unique case (code)
      3'h0: r = 4'h0;
      3'h1: r = 4'h2;
      3'h2: r = 4'h4;
      3'h3: r = 4'h6;
      3'h4: r = 4'h7;
      3'h5: r = 4'h8;
      3'h6: r = 4'h9;
      3'h7: r = 4'ha;
    endcase
    avg_shift = r;
  endfunction

  // selected threshold function against a result set; highest enable wins
  function automatic logic alert_hit(input logic [5:0] en, input logic [15:0] cur,
                                     input logic [15:0] bus, input logic [15:0] pwr,
                                     input logic [15:0] lim);
    logic r;
    r = 1'b0;
    if (en[pmac_pkg::EN_OCL])
      r = $signed(cur) > $signed(lim);
    else if (en[pmac_pkg::EN_UCL])
      r = $signed(cur) < $signed(lim);
    else if (en[pmac_pkg::EN_BOL])
      r = bus > lim;
    else if (en[pmac_pkg::EN_BUL])
      r = bus < lim;
    else if (en[pmac_pkg::EN_POL])
      r = pwr > lim;
    alert_hit = r;
  endfunction

  logic [2:0] mode;          // operating mode field
  logic [3:0] shift;         // log2 of samples per average
  logic [23:0] period;       // cycles per conversion
  logic running;             // converter active
  logic tick;                // one conversion completes
  logic cfg_wr;              // write to configuration register
  logic mask_rd;             // read of mask/enable register
  logic avg_clear;           // restart averaging
  logic signed [31:0] cur_sum;
  logic signed [31:0] bus_sum;
  logic [15:0] cur_avg;
  logic [15:0] bus_avg;
  logic cur_done;
  logic bus_done;
  logic [15:0] new_cur;
  logic [15:0] new_bus;
  logic [15:0] cur_mag;
  logic [31:0] prod;
  logic [31:0] early_thr;
  logic early_hit;
  logic final_hit;
  logic active;

  // operating fields and conversion pacing
  always_comb
  begin
    mode = s.cfg[pmac_pkg::CFG_MODE_LSB +: 3];
    shift = avg_shift(s.cfg[pmac_pkg::CFG_AVG_LSB +: 3]);
    period = ct_cycles(s.cfg[pmac_pkg::CFG_VCT_LSB +: 3])
           + ct_cycles(s.cfg[pmac_pkg::CFG_SCT_LSB +: 3]);
    running = (mode[1:0] != 2'h0) && (mode[pmac_pkg::MODE_CONT_BIT] || s.armed);
    cfg_wr = reg_wr_i && (reg_addr_i == pmac_pkg::ADDR_CFG);
    mask_rd = reg_rd_i && (reg_addr_i == pmac_pkg::ADDR_MASK);
    avg_clear = cfg_wr || !running;
    tick = running && !cfg_wr && (s.tmr >= period - 24'h1);
  end

  // current channel averager
  pmac_avg u_cur_avg (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(avg_clear),
    .sample_en_i(tick),
    .sample_i({current_i[15], current_i}),
    .shift_i(shift),
    .sum_o(cur_sum),
    .avg_o(cur_avg),
    .done_o(cur_done)
  );

  // bus voltage channel averager, unsigned samples
  pmac_avg u_bus_avg (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(avg_clear),
    .sample_en_i(tick),
    .sample_i({1'b0, bus_i}),
    .shift_i(shift),
    .sum_o(bus_sum),
    .avg_o(bus_avg),
    .done_o(bus_done)
  );

  // new results, power product and threshold checks
  always_comb
  begin
    new_cur = mode[0] ? cur_avg : s.cur; // RQ9
    new_bus = mode[1] ? bus_avg : s.bus; // RQ9
    cur_mag = new_cur[15] ? 16'(-new_cur) : new_cur;
    prod = cur_mag * new_bus; // RQ9
    final_hit = alert_hit(s.alert_en, new_cur, new_bus,
                          prod[pmac_pkg::PWR_SHIFT +: 16], s.limit); // RQ7 RQ3
    // bus sum only grows, so reaching (limit+1)*count early fixes the mean
    early_thr = (32'(s.limit) + 32'h1) << shift;
    early_hit = running && (s.alert_en[pmac_pkg::EN_OCL -: 3] == 3'h1) && mode[1]
              && ($unsigned(bus_sum) >= early_thr); // RQ4
  end

  // register file, flags and alert pin
  always_comb
  begin
    next_s = s;
    // conversion timer
    if (cfg_wr || !running)
      next_s.tmr = '0;
    else if (tick)
      next_s.tmr = '0;
    else
      next_s.tmr = s.tmr + 24'h1;
    // read data and read side effects
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        pmac_pkg::ADDR_CFG: next_s.rdata = s.cfg;
        pmac_pkg::ADDR_CUR: next_s.rdata = s.cur;
        pmac_pkg::ADDR_BUS: next_s.rdata = s.bus;
        pmac_pkg::ADDR_PWR: next_s.rdata = s.pwr;
        pmac_pkg::ADDR_MASK: next_s.rdata = {s.alert_en, 5'h00, s.aff, s.conversion_ready_flag,
                                             s.ovf, s.alert_polarity, s.len}; // RQ6
        pmac_pkg::ADDR_LIM: next_s.rdata = s.limit;
        pmac_pkg::ADDR_ID: next_s.rdata = {pmac_pkg::DEVICE_CODE,
                                           pmac_pkg::DIE_REVISION}; // RQ1
        default: next_s.rdata = 16'h0000;
      endcase
    end
    if (mask_rd)
    begin
      next_s.conversion_ready_flag = 1'b0;
      if (s.len)
        next_s.aff = 1'b0; // RQ10
    end
    // host writes
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        pmac_pkg::ADDR_CFG:
        begin
          next_s.cfg = {1'b0, reg_wdata_i[14:0]}; // RQ5
          next_s.armed = 1'b1;
          // power-down codes have both channel bits clear and keep the flag
          if (reg_wdata_i[pmac_pkg::CFG_MODE_LSB +: 2] != 2'h0)
            next_s.conversion_ready_flag = 1'b0;
        end
        pmac_pkg::ADDR_MASK:
        begin
          next_s.alert_en = reg_wdata_i[pmac_pkg::MASK_EN_LSB +: 6]; // RQ6 RQ2
          next_s.alert_polarity = reg_wdata_i[pmac_pkg::MASK_ALERT_POLARITY_BIT];
          next_s.len = reg_wdata_i[pmac_pkg::MASK_LEN_BIT];
        end
        pmac_pkg::ADDR_LIM: next_s.limit = reg_wdata_i; // RQ7
        default:
        begin
          next_s.limit = next_s.limit;
        end
      endcase
    end
    // end of an averaged conversion; set wins over any clear above
    if (cur_done && bus_done)
    begin
      next_s.cur = new_cur;
      next_s.bus = new_bus;
      next_s.pwr = prod[pmac_pkg::PWR_SHIFT +: 16];
      next_s.ovf = |prod[31:pmac_pkg::PWR_SHIFT + 16];
      next_s.conversion_ready_flag = 1'b1;
      if (!mode[pmac_pkg::MODE_CONT_BIT] && !cfg_wr)
        next_s.armed = 1'b0;
      if (final_hit)
        next_s.aff = 1'b1; // RQ3
      else if (!s.len && !early_hit)
        next_s.aff = 1'b0; // RQ10
    end
    if (early_hit)
      next_s.aff = 1'b1; // RQ4
    // self-clearing reset bit restores every register
    if (cfg_wr && reg_wdata_i[pmac_pkg::CFG_RST_BIT])
      next_s = ST_RESET; // RQ5
    // alert: selected function flag or conversion ready
    active = (next_s.aff && (|next_s.alert_en[5:1]))
           || (next_s.alert_en[pmac_pkg::EN_CONV_READY_ALERT_ENABLE] && next_s.conversion_ready_flag); // RQ2
    next_s.alert_oe = next_s.alert_polarity ? !active : active; // RQ11
    next_s.alert_lvl = 1'b0;
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s <= ST_RESET;
    else
      s <= next_s;
  end

  assign reg_rdata_o = s.rdata;
  assign alert_o = s.alert_lvl;
  assign alert_oe_o = s.alert_oe;

endmodule

// ===== bench/pmac_checker.sv
/* checker: port properties of the power monitor alert block.
   assumes it is bound to pmac_top with one clock and async low reset. */
`timescale 1ns/100ps
module pmac_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic alert_o,
  input wire logic alert_oe_o
);
  // single domain, reset disables every property
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  pin_never_high_a: assert property (!alert_o)
    else $error("alert pin value high");
  id_read_value_a: assert property (
    reg_rd_i && reg_addr_i == 8'hff |=>
    reg_rdata_o == {pmac_pkg::DEVICE_CODE, pmac_pkg::DIE_REVISION})
    else $error("id read wrong");
  limit_read_back_a: assert property (
    reg_wr_i && reg_addr_i == 8'h07 ##1 reg_rd_i && reg_addr_i == 8'h07 |=>
    reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("limit read back wrong");
  config_read_back_a: assert property (
    reg_wr_i && reg_addr_i == 8'h00 && !reg_wdata_i[15] ##1 reg_rd_i && reg_addr_i == 8'h00
    |=> reg_rdata_o[11:0] == $past(reg_wdata_i[11:0], 2))
    else $error("config read back wrong");
  reset_bit_zero_a: assert property (reg_rd_i && reg_addr_i == 8'h00 |=> !reg_rdata_o[15])
    else $error("config reset bit reads one");
  mask_unused_zero_a: assert property (
    reg_rd_i && reg_addr_i == 8'h06 |=> reg_rdata_o[9:5] == 5'h00)
    else $error("mask unused bits set");
  read_data_holds_a: assert property (
    !reg_rd_i && !(reg_wr_i && reg_addr_i == 8'h00 && reg_wdata_i[15]) |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  idle_polarity_a: assert property (
    reg_wr_i && reg_addr_i == 8'h06 && reg_wdata_i[15:10] == 6'h00 |->
    ##2 alert_oe_o == $past(reg_wdata_i[1], 2))
    else $error("idle pin level wrong");
endmodule
bind pmac_top pmac_checker u_checker (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .alert_o(alert_o), .alert_oe_o(alert_oe_o)
);

// ===== bench/pmac_host.sv
/* host model: issues decoded register reads and writes.
   assumes tasks are entered on a falling edge; each ends on one. */
`timescale 1ns/100ps
module pmac_host (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [15:0] wdata_o
);
  // idle bus at time zero
  initial
  begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 16'h0000;
  end
  // one write cycle; strobe left for the next call to settle
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr_o = a;
    wdata_o = d;
    rd_o = 1'b0;
    wr_o = 1'b1;
    @(negedge clk_i);
  endtask
  // one read cycle; data is registered at the strobe edge
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    addr_o = a;
    wdata_o = ~wdata_o;
    wr_o = 1'b0;
    rd_o = 1'b1;
    @(negedge clk_i);
    d = rdata_i;
  endtask
  // no access; unused write data keeps toggling
  task automatic idle(input int n);
    wr_o = 1'b0;
    rd_o = 1'b0;
    repeat (n)
    begin
      wdata_o = ~wdata_o;
      @(negedge clk_i);
    end
  endtask
endmodule

// ===== bench/power_monitor_alert_config_test.sv
/* testbench: register map, alert functions, latch, polarity, results.
   assumes pmac_top with a shortened conversion unit of 4 cycles. */
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module power_monitor_alert_config_test;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [15:0] reg_wdata_i;
  logic [15:0] reg_rdata_o;
  logic [15:0] current_i = 16'h0000;
  logic [15:0] bus_i = 16'h0000;
  logic alert_o;
  logic alert_oe_o;
  logic [15:0] rd;
  logic [31:0] lfsr = 32'hd1b550fa;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  always #50 clk_i = ~clk_i;
  pmac_top #(.CONV_UNIT_CYCLES(4)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .current_i(current_i),
    .bus_i(bus_i), .alert_o(alert_o), .alert_oe_o(alert_oe_o));
  pmac_host u_host (.clk_i(clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
    .wr_o(reg_wr_i), .rd_o(reg_rd_i), .wdata_o(reg_wdata_i));
  // shift register for repeatable random values
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected power: magnitude of current times bus, scaled down
  function automatic logic [15:0] pwr_exp(input logic [15:0] c, input logic [15:0] b);
    logic [31:0] p;
    p = {16'h0000, (c[15] ? -c : c)} * {16'h0000, b};
    return p[23:8];
  endfunction
  task automatic print_verdict;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // wait a bounded time for the pin enable to reach a level
  task automatic wait_oe(input logic lvl, input int max);
    for (int i = 0; i < max && alert_oe_o !== lvl; i++)
      u_host.idle(1);
  endtask
  // hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    u_host.rd_reg(8'h00, rd);
    `CHK(rd, 16'h6007)
    u_host.wr_reg(8'hff, 16'h1234);
    u_host.rd_reg(8'hff, rd);
    `CHK(rd, {pmac_pkg::DEVICE_CODE, pmac_pkg::DIE_REVISION})
    // random write and read back of limit, mask and configuration
    for (int k = 0; k < 20; k++)
    begin
      lfsr = next_rand(lfsr);
      u_host.wr_reg(8'h07, lfsr[15:0]);
      u_host.rd_reg(8'h07, rd);
      `CHK(rd, lfsr[15:0])
      u_host.wr_reg(8'h06, lfsr[31:16] & 16'hfc03);
      u_host.rd_reg(8'h06, rd);
      `CHK(rd & 16'hfc03, lfsr[31:16] & 16'hfc03)
      u_host.wr_reg(8'h00, lfsr[27:12] & 16'h0fff);
      u_host.rd_reg(8'h00, rd);
      `CHK(rd & 16'h8fff, lfsr[27:12] & 16'h0fff)
    end
    // each threshold function: hit raises, a clean conversion clears
    u_host.wr_reg(8'h00, 16'h0007);
    u_host.wr_reg(8'h07, 16'h0200);
    // flags left by the random masks clear on a quiet transparent conversion
    u_host.wr_reg(8'h06, 16'h0000);
    u_host.idle(12);
    for (int f = 0; f < 5; f++)
    begin
      current_i = (f == 1) ? 16'h0100 : 16'h0300;
      bus_i = (f == 3) ? 16'h0100 : 16'h0300;
      u_host.wr_reg(8'h06, 16'h8000 >> f);
      `CHK(alert_oe_o, 1'b0)
      wait_oe(1'b1, 24);
      `CHK(alert_oe_o, 1'b1)
      current_i = (f == 1 || f == 3) ? 16'h0300 : 16'h0100;
      bus_i = current_i;
      wait_oe(1'b0, 24);
      `CHK(alert_oe_o, 1'b0)
    end
    // scaled results with a negative current
    current_i = 16'hff00;
    u_host.idle(20);
    u_host.rd_reg(8'h03, rd);
    `CHK(rd, pwr_exp(current_i, bus_i))
    u_host.rd_reg(8'h01, rd);
    `CHK(rd, current_i)
    // product beyond the power format raises the overflow flag
    current_i = 16'h4000;
    bus_i = 16'h0800;
    u_host.idle(12);
    u_host.rd_reg(8'h06, rd);
    `CHK(rd[2], 1'b1)
    // latch mode holds until the mask is read
    u_host.wr_reg(8'h06, 16'h2001);
    bus_i = 16'h0300;
    wait_oe(1'b1, 24);
    bus_i = 16'h0100;
    u_host.idle(30);
    `CHK(alert_oe_o, 1'b1)
    u_host.rd_reg(8'h06, rd);
    `CHK(rd[4], 1'b1)
    wait_oe(1'b0, 24);
    `CHK(alert_oe_o, 1'b0)
    // inverted polarity: idle drives, alert releases
    u_host.wr_reg(8'h06, 16'h0002);
    u_host.idle(3);
    `CHK(alert_oe_o, 1'b1)
    u_host.wr_reg(8'h06, 16'h2002);
    bus_i = 16'h0300;
    wait_oe(1'b0, 24);
    `CHK(alert_oe_o, 1'b0)
    // conversion ready as the alert source
    u_host.wr_reg(8'h06, 16'h0400);
    wait_oe(1'b1, 24);
    `CHK(alert_oe_o, 1'b1)
    // four-sample average: a large fault alerts before the average ends
    bus_i = 16'h0100;
    u_host.idle(12);
    u_host.wr_reg(8'h07, 16'h0100);
    u_host.wr_reg(8'h00, 16'h0207);
    u_host.wr_reg(8'h06, 16'h2000);
    `CHK(alert_oe_o, 1'b0)
    bus_i = 16'hffff;
    wait_oe(1'b1, 14);
    `CHK(alert_oe_o, 1'b1)
    print_verdict();
  end
endmodule
